// [design/tlr_pkg.sv]
// Shared constants and carrier types for the transmit length register bank
package tlr_pkg;

  // Register port geometry
  localparam int unsigned TLR_ADDR_W = 5;
  localparam int unsigned TLR_DATA_W = 8;
  localparam int unsigned TLR_NUM_REGS = 2;
  localparam int unsigned TLR_COUNT_W = 12;
  localparam int unsigned TLR_PART_W = 4;

  // Register offsets
  localparam logic [TLR_ADDR_W-1:0] TLR_OFF_HIGH = 5'h1d;
  localparam logic [TLR_ADDR_W-1:0] TLR_OFF_LOW  = 5'h1e;

  // Reset value of both registers and of unmapped reads
  localparam logic [TLR_DATA_W-1:0] TLR_RESET_VAL = 8'h00;
  localparam logic [TLR_DATA_W-1:0] TLR_UNMAPPED  = 8'h00;

  // Register indices inside the bank
  localparam int unsigned TLR_IDX_HIGH = 0;
  localparam int unsigned TLR_IDX_LOW  = 1;

  // Field positions in the high register
  localparam int unsigned TLR_HI_TOP_MSB = 7;
  localparam int unsigned TLR_HI_TOP_LSB = 4;
  localparam int unsigned TLR_HI_MID_MSB = 3;
  localparam int unsigned TLR_HI_MID_LSB = 0;

  // Field positions in the low register
  localparam int unsigned TLR_LO_B3_POS  = 7;
  localparam int unsigned TLR_LO_B20_MSB = 6;
  localparam int unsigned TLR_LO_B20_LSB = 4;
  localparam int unsigned TLR_LO_PART_MSB = 3;
  localparam int unsigned TLR_LO_PART_LSB = 0;

  // Host request toward the register bank
  typedef struct packed {
    logic [TLR_ADDR_W-1:0] addr;
    logic                  wr;
    logic                  rd;
    logic [TLR_DATA_W-1:0] wdata;
  } tlr_req_s;

  // State of one register cell
  typedef struct packed {
    logic [TLR_DATA_W-1:0] value;
  } tlr_cell_s;

  // State of the bank top
  typedef struct packed {
    logic [TLR_DATA_W-1:0] rdata;
  } tlr_top_s;

endpackage

// [design/tlr_cell.sv]
// One 8-bit length register with hold clear, end-of-frame clear and host write
`timescale 1ns/10ps
module tlr_cell (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Controls
  input  wire logic                          hold_clr,
  input  wire logic                          eof_clr,
  input  wire logic                          wr,
  input  wire logic [tlr_pkg::TLR_DATA_W-1:0] wdata,
  // Stored value
  output      logic [tlr_pkg::TLR_DATA_W-1:0] q
);

  tlr_pkg::tlr_cell_s state_r;
  tlr_pkg::tlr_cell_s state_nxt;

  // Disabled chip wins, a host write beats the frame-end clear
  always_comb begin
    state_nxt = state_r;
    if (hold_clr) begin
      state_nxt.value = tlr_pkg::TLR_RESET_VAL;
    end else if (wr) begin
      state_nxt.value = wdata;
    end else if (eof_clr) begin
      state_nxt.value = tlr_pkg::TLR_RESET_VAL;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r.value <= tlr_pkg::TLR_RESET_VAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign q = state_r.value;

endmodule

// [design/tlr_bank.sv]
// Transmit length register bank: complete-byte count and partial-byte field
//
// Summary of operation
// - High register bits 7:4 hold count 11:8
// - High register bits 3:0 hold count 7:4
// - Low register: count low nibble, partial-byte information
// - Low register bit 7 holds count 3
// - Both clear at reset, held clear while disabled
// - Both clear automatically at transmit end-of-frame, except a register written in the same cycle
// - Low register bits 6:4 hold count 2:0
`timescale 1ns/10ps
module tlr_bank (
  // Clock and reset
  input  wire logic                               CLK,
  input  wire logic                               RST,
  // Chip enable, low holds the bank cleared
  input  wire logic                               EN,
  // Transmit end-of-frame pulse from the framer
  input  wire logic                               TX_EOF,
  // Host register port
  input  wire tlr_pkg::tlr_req_s                  REG_REQ,
  output      logic [tlr_pkg::TLR_DATA_W-1:0]     REG_RDATA,
  // Length toward the framer
  output      logic [tlr_pkg::TLR_COUNT_W-1:0]    COMPLETE_BYTE_COUNT,
  output      logic [tlr_pkg::TLR_PART_W-1:0]     PARTIAL_INFO
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic addr_hit(input logic [tlr_pkg::TLR_ADDR_W-1:0] addr,
                                    input logic [tlr_pkg::TLR_ADDR_W-1:0] off);
    addr_hit = (addr == off);
  endfunction

  localparam logic [tlr_pkg::TLR_ADDR_W-1:0] REG_OFFS [tlr_pkg::TLR_NUM_REGS] = '{
    tlr_pkg::TLR_OFF_HIGH,
    tlr_pkg::TLR_OFF_LOW
  };

  logic [tlr_pkg::TLR_DATA_W-1:0] reg_q [tlr_pkg::TLR_NUM_REGS];
  logic                           hold_clr;

  assign hold_clr = ~EN;

  ////////////////////////////////////////////////////////////////////////////
  // Register cells

  for (genvar gi = 0; gi < tlr_pkg::TLR_NUM_REGS; gi++) begin : g_cell
    tlr_cell u_cell (
      .clk      (CLK),
      .rst      (RST),
      .hold_clr (hold_clr),
      .eof_clr  (TX_EOF),
      .wr       (REG_REQ.wr & addr_hit(REG_REQ.addr, REG_OFFS[gi])),
      .wdata    (REG_REQ.wdata),
      .q        (reg_q[gi])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field mapping toward the framer

  logic [tlr_pkg::TLR_DATA_W-1:0] high_q;
  logic [tlr_pkg::TLR_DATA_W-1:0] low_q;

  assign high_q = reg_q[tlr_pkg::TLR_IDX_HIGH];
  assign low_q  = reg_q[tlr_pkg::TLR_IDX_LOW];

  assign COMPLETE_BYTE_COUNT = {
    high_q[tlr_pkg::TLR_HI_TOP_MSB:tlr_pkg::TLR_HI_TOP_LSB],
    high_q[tlr_pkg::TLR_HI_MID_MSB:tlr_pkg::TLR_HI_MID_LSB],
    low_q[tlr_pkg::TLR_LO_B3_POS],
    low_q[tlr_pkg::TLR_LO_B20_MSB:tlr_pkg::TLR_LO_B20_LSB]
  };

  assign PARTIAL_INFO = low_q[tlr_pkg::TLR_LO_PART_MSB:tlr_pkg::TLR_LO_PART_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  tlr_pkg::tlr_top_s state_r;
  tlr_pkg::tlr_top_s state_nxt;

  // Read data is latched on a read strobe and held until the next one
  always_comb begin
    state_nxt = state_r;
    if (REG_REQ.rd) begin
      if (addr_hit(REG_REQ.addr, tlr_pkg::TLR_OFF_HIGH)) begin
        state_nxt.rdata = high_q;
      end else if (addr_hit(REG_REQ.addr, tlr_pkg::TLR_OFF_LOW)) begin
        state_nxt.rdata = low_q;
      end else begin
        state_nxt.rdata = tlr_pkg::TLR_UNMAPPED;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r.rdata <= tlr_pkg::TLR_RESET_VAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign REG_RDATA = state_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic wr_high;
  logic wr_low;

  assign wr_high = REG_REQ.wr & addr_hit(REG_REQ.addr, tlr_pkg::TLR_OFF_HIGH);
  assign wr_low  = REG_REQ.wr & addr_hit(REG_REQ.addr, tlr_pkg::TLR_OFF_LOW);

  sequence s_wr_high;
    EN && wr_high;
  endsequence

  sequence s_wr_low;
    EN && wr_low;
  endsequence

  sequence s_idle_eof;
    EN && TX_EOF && !REG_REQ.wr;
  endsequence

  property p_top_nibble;
    @(posedge CLK) disable iff (RST)
      s_wr_high |=> COMPLETE_BYTE_COUNT[11:8] == $past(REG_REQ.wdata[7:4]);
  endproperty
  a_top_nibble: assert property (p_top_nibble)
    else $error("count bits 11:8 do not follow high register write");

  property p_mid_nibble;
    @(posedge CLK) disable iff (RST)
      s_wr_high |=> COMPLETE_BYTE_COUNT[7:4] == $past(REG_REQ.wdata[3:0]);
  endproperty
  a_mid_nibble: assert property (p_mid_nibble)
    else $error("count bits 7:4 do not follow high register write");

  property p_low_readback;
    @(posedge CLK) disable iff (RST)
      s_wr_low ##1 (REG_REQ.rd && !REG_REQ.wr && EN && !TX_EOF &&
                    addr_hit(REG_REQ.addr, tlr_pkg::TLR_OFF_LOW))
      |=> REG_RDATA == $past(REG_REQ.wdata, 2) &&
          PARTIAL_INFO == REG_RDATA[3:0];
  endproperty
  a_low_readback: assert property (p_low_readback)
    else $error("low register read back does not match write");

  property p_count_bit3;
    @(posedge CLK) disable iff (RST)
      s_wr_low |=> COMPLETE_BYTE_COUNT[3] == $past(REG_REQ.wdata[7]);
  endproperty
  a_count_bit3: assert property (p_count_bit3)
    else $error("count bit 3 does not follow low register bit 7");

  property p_hold_clear;
    @(posedge CLK) disable iff (RST)
      !EN [*2] |-> COMPLETE_BYTE_COUNT == 12'h000 && PARTIAL_INFO == 4'h0;
  endproperty
  a_hold_clear: assert property (p_hold_clear)
    else $error("registers not held clear while chip disabled");

  property p_eof_clear;
    @(posedge CLK) disable iff (RST)
      s_idle_eof |=> COMPLETE_BYTE_COUNT == 12'h000 && PARTIAL_INFO == 4'h0;
  endproperty
  a_eof_clear: assert property (p_eof_clear)
    else $error("registers not cleared at transmit end of frame");

  property p_low_bits;
    @(posedge CLK) disable iff (RST)
      s_wr_low |=> COMPLETE_BYTE_COUNT[2:0] == $past(REG_REQ.wdata[6:4]);
  endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("count bits 2:0 do not follow low register write");

  property p_quiet_hold;
    @(posedge CLK) disable iff (RST)
      EN && !TX_EOF && !REG_REQ.wr && $past(EN)
      |=> $stable(COMPLETE_BYTE_COUNT) && $stable(PARTIAL_INFO);
  endproperty
  a_quiet_hold: assert property (p_quiet_hold)
    else $error("length changed without write or end of frame");

endmodule

// [test/tlr_host.sv]
// Host model that drives the register port of the length bank
`timescale 1ns/10ps
module tlr_host (
  // Clock
  input  wire logic              clk,
  // Register request toward the bank
  output      tlr_pkg::tlr_req_s req
);
  initial req = '0;

  // One request per edge, changed just after the edge and held through it
  task automatic op(input logic [4:0] a, input logic w, input logic r, input logic [7:0] d);
    @(posedge clk);
    #1;
    req = '{addr: a, wr: w, rd: r, wdata: d};
  endtask

  // Released lines show the inverse of their last value
  task automatic idle();
    op(~req.addr, 1'h0, 1'h0, ~req.wdata);
  endtask

  // Both lengths are written before every frame
  task automatic load(input logic [7:0] hi, input logic [7:0] lo);
    op(tlr_pkg::TLR_OFF_HIGH, 1'h1, 1'h0, hi);
    op(tlr_pkg::TLR_OFF_LOW, 1'h1, 1'h0, lo);
  endtask
endmodule

// [test/tb.sv]
// Self-checking testbench for the transmit length register bank
`timescale 1ns/10ps
module tb;
  logic              CLK;
  logic              RST;
  logic              EN;
  logic              TX_EOF;
  tlr_pkg::tlr_req_s REG_REQ;
  logic [7:0]        REG_RDATA;
  logic [11:0]       COMPLETE_BYTE_COUNT;
  logic [3:0]        PARTIAL_INFO;
  int                n_mismatch;
  int                num_checks;
  logic [7:0]        exp_q[$];
  logic              pend;
  logic [7:0]        hi;
  logic [7:0]        lo;

  tlr_bank dut_u (.CLK(CLK), .RST(RST), .EN(EN), .TX_EOF(TX_EOF), .REG_REQ(REG_REQ),
    .REG_RDATA(REG_RDATA), .COMPLETE_BYTE_COUNT(COMPLETE_BYTE_COUNT),
    .PARTIAL_INFO(PARTIAL_INFO));
  tlr_host host_u (.clk(CLK), .req(REG_REQ));

  initial begin
    CLK = 1'h0;
    forever #20 CLK = ~CLK;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.op(a, 1'h0, 1'h1, 8'h00);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Read data is due at the same edge that takes the strobe
  always @(posedge CLK) begin
    #2;
    if (pend) chk(12'(REG_RDATA), 12'(exp_q.pop_front()));
    pend = REG_REQ.rd;
  end

  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    RST = 1'h1;
    EN = 1'h1;
    TX_EOF = 1'h0;
    pend = 1'h0;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(32'hab12));
    repeat (3) @(posedge CLK);
    #1 RST = 1'h0;
    rd(tlr_pkg::TLR_OFF_HIGH, 8'h00);
    rd(tlr_pkg::TLR_OFF_LOW, 8'h00);
    host_u.idle();
    chk(COMPLETE_BYTE_COUNT, 12'h000);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      hi = (i == 0) ? 8'hff : 8'($urandom);
      lo = (i == 0) ? 8'hff : 8'($urandom);
      host_u.load(hi, lo);
      host_u.idle();
      chk(COMPLETE_BYTE_COUNT, {hi, lo[7:4]});
      chk(12'(COMPLETE_BYTE_COUNT[7:4]), 12'(hi[3:0]));
      chk(12'(COMPLETE_BYTE_COUNT[3]), 12'(lo[7]));
      chk(12'(COMPLETE_BYTE_COUNT[2:0]), 12'(lo[6:4]));
      chk(12'(PARTIAL_INFO), 12'(lo[3:0]));
      rd(tlr_pkg::TLR_OFF_HIGH, hi);
      rd(tlr_pkg::TLR_OFF_LOW, lo);
    end
    rd(5'h1c, 8'h00);
    $display("test write and read done");
    host_u.load(8'h5a, 8'hc3);
    host_u.idle();
    TX_EOF = 1'h1;
    host_u.idle();
    TX_EOF = 1'h0;
    chk(COMPLETE_BYTE_COUNT, 12'h000);
    chk(12'(PARTIAL_INFO), 12'h000);
    rd(tlr_pkg::TLR_OFF_LOW, 8'h00);
    host_u.load(8'h5a, 8'hc3);
    host_u.op(tlr_pkg::TLR_OFF_LOW, 1'h1, 1'h0, 8'h96);
    TX_EOF = 1'h1;
    host_u.idle();
    TX_EOF = 1'h0;
    chk(COMPLETE_BYTE_COUNT, 12'h009);
    chk(12'(PARTIAL_INFO), 12'h006);
    $display("test end of frame done");
    host_u.load(8'h5a, 8'hc3);
    host_u.idle();
    EN = 1'h0;
    host_u.op(tlr_pkg::TLR_OFF_HIGH, 1'h1, 1'h0, 8'hff);
    host_u.idle();
    chk(COMPLETE_BYTE_COUNT, 12'h000);
    EN = 1'h1;
    host_u.idle();
    chk(COMPLETE_BYTE_COUNT, 12'h000);
    rd(tlr_pkg::TLR_OFF_HIGH, 8'h00);
    host_u.idle();
    $display("test enable low done");
    // Read straight after a write, then a write and read in one cycle
    host_u.load(8'h5a, 8'hc3);
    rd(tlr_pkg::TLR_OFF_LOW, 8'hc3);
    exp_q.push_back(8'hc3);
    host_u.op(tlr_pkg::TLR_OFF_LOW, 1'h1, 1'h1, 8'h3c);
    host_u.idle();
    host_u.idle();
    chk(12'(PARTIAL_INFO), 12'h00c);
    chk(COMPLETE_BYTE_COUNT, 12'h5a3);
    // Reset in mid-run clears loaded lengths and read data
    RST = 1'h1;
    host_u.idle();
    chk(COMPLETE_BYTE_COUNT, 12'h000);
    chk(12'(REG_RDATA), 12'h000);
    chk(12'(PARTIAL_INFO), 12'h000);
    RST = 1'h0;
    rd(tlr_pkg::TLR_OFF_HIGH, 8'h00);
    host_u.idle();
    $display("test readback and reset done");
    repeat (2) @(posedge CLK);
    summarize();
  end
endmodule
